// [plf_defines.vh]
// Constants for the PCM link clock and framing block.
// Assumes inclusion by bare name from the design file.
`ifndef PLF_DEFINES_VH
`define PLF_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PLF_LINK_CFG     8'h00
`define PLF_RX_SYNC_STAT 8'h20
`define PLF_TX_SYNC_STAT 8'h24
`define PLF_PLL_REF_CTRL 8'h28
`define PLF_CLK_ACT      8'h2c

// ----------------------------------------------------------------
// Link control fields
// ----------------------------------------------------------------
`define PLF_F_MODE_LSB   0
`define PLF_F_MODE_MSB   3
`define PLF_B_RATE       4
`define PLF_B_SPACED     5
`define PLF_B_TXEDGE     6
`define PLF_B_RXEDGE     7
`define PLF_B_TXPOL      8
`define PLF_B_RXPOL      9
`define PLF_F_SF_LSB     10
`define PLF_F_SF_MSB     11
`define PLF_F_SRC_LSB    12
`define PLF_F_SRC_MSB    15
`define PLF_CFG_RST      16'h0003

// ----------------------------------------------------------------
// Reference control and clock activity fields
// ----------------------------------------------------------------
`define PLF_F_PRI_LSB    0
`define PLF_F_PRI_MSB    2
`define PLF_F_SEC_LSB    3
`define PLF_F_SEC_MSB    5
`define PLF_B_SEL_RST    7
`define PLF_PLLREF_RST   6'h08
`define PLF_B_ACTIVE     7
`define PLF_ACT_ID_RST   5'h00

// ----------------------------------------------------------------
// Frame geometry
// ----------------------------------------------------------------
`define PLF_T1_LAST      8'hc0
`define PLF_FRM_LAST     8'hff
`define PLF_SF12_LAST    5'h0b
`define PLF_SF24_LAST    5'h17
`define PLF_T1_GROUPED   5'h18
`define PLF_E1_SIG_CH    5'h10

`endif

// [plf_pcm_link.v]
// PCM link clocking, framing and channel mapping for eight T1/E1 links.
// Assumes one pclk domain; every pin input is asynchronous and is
// synchronised here. Link clocks must be well below pclk / 4.
`include "plf_defines.vh"

// Notes on behaviour
// - E1: timeslots 1-15 on channels 1-15, 16-30 on 17-31; 0, 16 unused.
// - Tx clock and frame pulse driven in modes 1,3,6,8; inputs in 2,4,5,7.
// - Bit 4 clear in modes 1 and 5: generic T1 at line rate, 193-bit frames.
// - 1.544 MHz sub-mode: clocks 1.544 MHz, frame pulses at 8 kHz.
// - 1.544 MHz sub-mode: framing bit ignored both ways, marked by pulses.
// - Bit 4 set: generic T1 at 2.048 MHz with grouped or spaced mapping.
// - 2.048 MHz T1: frame pulses one bit long at frame start, 8 kHz.
// - Software sets polarity and edge of both clocks and frame pulses.
// - Per link, software picks sampling edge and launch edge.
// - Generic E1: 2.048 MHz clocks, one-cycle pulse on first bit.
// - Input tx frame pulse is sampled at the bit boundary.
// - Output tx clock sourced from any rx or reference clock; pulse derived.
// - Receive clocks are always inputs.
// - Receive pulse checked per frame or superframe; flag and realign.
// - Input tx pulse checked per frame or superframe; flag and realign.
// - Primary and secondary PLL references forward any rx clock.
// - Clock activity register reports transitions on chosen clock in bit 7.
// - Tx clock source switch is glitch free except on selector reset, which switches at once.
// - Writing 1 to bit 7 of PLL reference control resets clock selector.
// - Spaced T1: channels 0,4,...,28 unused, tx data released.
// - Grouped T1: first 24 channels used, tx data released afterwards.
module plf_pcm_link #(
  parameter LINKS = 8
) (
  // APB
  input  wire         pclk,
  input  wire         presetn,
  input  wire         psel,
  input  wire         penable,
  input  wire         pwrite,
  input  wire [7:0]   paddr,
  input  wire [31:0]  pwdata,
  output reg  [31:0]  prdata,
  output reg          pready,
  output reg          pslverr,
  // Receive pins
  input  wire [7:0]   rx_pcm_clock,
  input  wire [7:0]   rx_frame_pulse,
  input  wire [7:0]   rx_serial_data,
  input  wire [3:0]   reference_clock_input,
  // Transmit pins
  input  wire [7:0]   tx_pcm_clock_i,
  output reg  [7:0]   tx_pcm_clock_o,
  output reg  [7:0]   tx_pcm_clock_oe,
  input  wire [7:0]   tx_frame_pulse_i,
  output reg  [7:0]   tx_frame_pulse_o,
  output reg  [7:0]   tx_frame_pulse_oe,
  output reg  [7:0]   tx_serial_data_o,
  output reg  [7:0]   tx_serial_data_oe,
  // PLL references
  output reg          pll_primary_ref_out,
  output reg          pll_secondary_ref_out,
  // Payload side
  output reg  [63:0]  rx_payload,
  output reg  [7:0]   rx_payload_valid,
  input  wire [63:0]  tx_payload,
  output reg  [7:0]   tx_payload_take
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function is_e1;
    input [3:0] m;
    begin
      is_e1 = (m == 4'h3) || (m == 4'h4) || (m == 4'h7) || (m == 4'h8);
    end
  endfunction

  function is_t1_line;
    input [3:0] m;
    input       rate;
    begin
      is_t1_line = ((m == 4'h1) || (m == 4'h5)) && !rate;
    end
  endfunction

  function tx_drives;
    input [3:0] m;
    begin
      tx_drives = (m == 4'h1) || (m == 4'h3) || (m == 4'h6) || (m == 4'h8);
    end
  endfunction

  function [7:0] frame_last;
    input [3:0] m;
    input       rate;
    begin
      frame_last = is_t1_line(m, rate) ? `PLF_T1_LAST : `PLF_FRM_LAST;
    end
  endfunction

  function [4:0] sf_last;
    input [1:0] sf;
    begin
      case (sf)
        2'h1:    sf_last = `PLF_SF12_LAST;
        2'h2:    sf_last = `PLF_SF24_LAST;
        default: sf_last = 5'h00;
      endcase
    end
  endfunction

  function payload_bit;
    input [7:0] b;
    input [3:0] m;
    input       rate;
    input       spaced;
    begin
      if (is_e1(m))
        payload_bit = (b[7:3] != 5'h00) && (b[7:3] != `PLF_E1_SIG_CH);
      else if (is_t1_line(m, rate))
        payload_bit = (b != 8'h00);
      else if (spaced)
        payload_bit = (b[4:3] != 2'h0);
      else
        payload_bit = (b[7:3] < `PLF_T1_GROUPED);
    end
  endfunction

  function [7:0] bit_step;
    input [7:0] cnt;
    input [7:0] last;
    begin
      bit_step = (cnt >= last) ? 8'h00 : cnt + 8'h01;
    end
  endfunction

  function [4:0] frm_step;
    input [4:0] frm;
    input [7:0] cnt;
    input [7:0] last;
    input [4:0] flast;
    begin
      if (cnt < last)
        frm_step = frm;
      else
        frm_step = (frm >= flast) ? 5'h00 : frm + 5'h01;
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire [43:0] pin_raw = {reference_clock_input, tx_frame_pulse_i, tx_pcm_clock_i,
                         rx_serial_data, rx_frame_pulse, rx_pcm_clock};
  reg  [43:0] pin_m_r;
  reg  [43:0] pin_s_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_m_r <= 44'h0;
      pin_s_r <= 44'h0;
    end else begin
      pin_m_r <= pin_raw;
      pin_s_r <= pin_m_r;
    end
  end

  wire [7:0] rx_pcm_clock_s = pin_s_r[7:0];
  wire [7:0] rxfp_s = pin_s_r[15:8];
  wire [7:0] rxd_s  = pin_s_r[23:16];
  wire [7:0] tx_pcm_clock_s = pin_s_r[31:24];
  wire [7:0] txfp_s = pin_s_r[39:32];
  wire [3:0] ref_s  = pin_s_r[43:40];
  wire [11:0] src_v = {ref_s, rx_pcm_clock_s};

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  reg  [15:0] cfg_r [0:7];
  reg  [5:0]  pllref_r;
  reg  [4:0]  act_id_r;
  reg         sel_rst_r;
  reg         act_clr_r;
  reg         act_seen_r;
  wire [7:0]  rx_stat;
  wire [7:0]  tx_stat;
  wire [7:0]  tx_lvl;
  reg  [7:0]  tx_lvl_p_r;
  reg  [3:0]  ref_p_r;
  reg  [7:0]  rx_pcm_clock_p_r;

  wire        acc    = psel && penable && pready;
  wire        wr     = acc && pwrite;
  wire        is_cfg = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
  wire [7:0]  rx_clr = (wr && paddr == `PLF_RX_SYNC_STAT) ? pwdata[7:0] : 8'h00;
  wire [7:0]  tx_clr = (wr && paddr == `PLF_TX_SYNC_STAT) ? pwdata[7:0] : 8'h00;
  reg  [31:0] rd_val;
  reg         rd_err;

  always @* begin
    rd_val = 32'h0;
    rd_err = 1'b0;
    if (is_cfg)
      rd_val = {16'h0, cfg_r[paddr[4:2]]};
    else if (paddr == `PLF_RX_SYNC_STAT)
      rd_val = {24'h0, rx_stat};
    else if (paddr == `PLF_TX_SYNC_STAT)
      rd_val = {24'h0, tx_stat};
    else if (paddr == `PLF_PLL_REF_CTRL)
      rd_val = {26'h0, pllref_r};
    else if (paddr == `PLF_CLK_ACT)
      rd_val = {24'h0, act_seen_r, 2'h0, act_id_r};
    else
      rd_err = 1'b1;
  end

  // One wait state so read data comes from a flop
  always @(posedge pclk or negedge presetn) begin : apb_proc
    integer k;
    if (!presetn) begin
      for (k = 0; k < 8; k = k + 1)
        cfg_r[k] <= `PLF_CFG_RST;
      pllref_r  <= `PLF_PLLREF_RST;
      act_id_r  <= `PLF_ACT_ID_RST;
      sel_rst_r <= 1'b0;
      act_clr_r <= 1'b0;
      prdata    <= 32'h0;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
    end else begin
      sel_rst_r <= 1'b0;
      act_clr_r <= 1'b0;
      if (psel && penable && !pready) begin
        pready  <= 1'b1;
        prdata  <= pwrite ? 32'h0 : rd_val;
        pslverr <= rd_err;
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
      if (wr) begin
        if (is_cfg)
          cfg_r[paddr[4:2]] <= pwdata[15:0];
        if (paddr == `PLF_PLL_REF_CTRL) begin
          pllref_r  <= pwdata[5:0];
          sel_rst_r <= pwdata[`PLF_B_SEL_RST];
        end
        if (paddr == `PLF_CLK_ACT) begin
          act_id_r  <= pwdata[4:0];
          act_clr_r <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock activity and PLL references
  // ----------------------------------------------------------------
  wire [19:0] clk_now  = {ref_s, tx_lvl, rx_pcm_clock_s};
  wire [19:0] clk_prev = {ref_p_r, tx_lvl_p_r, rx_pcm_clock_p_r};
  wire        act_edge = (act_id_r < 5'h14) &&
                         (clk_now[act_id_r] != clk_prev[act_id_r]);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_p_r               <= 4'h0;
      rx_pcm_clock_p_r              <= 8'h0;
      tx_lvl_p_r            <= 8'h0;
      act_seen_r            <= 1'b0;
      pll_primary_ref_out   <= 1'b0;
      pll_secondary_ref_out <= 1'b0;
    end else begin
      ref_p_r    <= ref_s;
      rx_pcm_clock_p_r   <= rx_pcm_clock_s;
      tx_lvl_p_r <= tx_lvl;
      // An edge on the new clock in the cycle after the identity write still counts
      if (act_edge)
        act_seen_r <= 1'b1;
      else if (act_clr_r)
        act_seen_r <= 1'b0;
      pll_primary_ref_out   <= rx_pcm_clock_s[pllref_r[`PLF_F_PRI_MSB:`PLF_F_PRI_LSB]];
      pll_secondary_ref_out <= rx_pcm_clock_s[pllref_r[`PLF_F_SEC_MSB:`PLF_F_SEC_LSB]];
    end
  end

  // ----------------------------------------------------------------
  // Per-link receive and transmit framing
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < LINKS; g = g + 1) begin : link
      wire [15:0] cfg    = cfg_r[g];
      wire [3:0]  mode   = cfg[`PLF_F_MODE_MSB:`PLF_F_MODE_LSB];
      wire        rate   = cfg[`PLF_B_RATE];
      wire        spaced = cfg[`PLF_B_SPACED];
      wire [7:0]  last   = frame_last(mode, rate);
      wire [4:0]  flast  = sf_last(cfg[`PLF_F_SF_MSB:`PLF_F_SF_LSB]);
      wire [3:0]  src    = cfg[`PLF_F_SRC_MSB:`PLF_F_SRC_LSB];
      wire [3:0]  want   = (src > 4'hb) ? 4'h0 : src;
      wire        drive  = tx_drives(mode);

      // Receive side
      reg  [7:0] rx_cnt_r;
      reg  [4:0] rx_frm_r;
      reg  [2:0] rx_nb_r;
      reg  [7:0] rx_sh_r;
      reg        rx_st_r;
      wire rx_smp = cfg[`PLF_B_RXEDGE] ? (rx_pcm_clock_p_r[g] && !rx_pcm_clock_s[g])
                                       : (!rx_pcm_clock_p_r[g] && rx_pcm_clock_s[g]);
      wire rx_fp  = rxfp_s[g] ^ cfg[`PLF_B_RXPOL];
      wire [7:0] rx_cn = bit_step(rx_cnt_r, last);
      wire [4:0] rx_fn = frm_step(rx_frm_r, rx_cnt_r, last, flast);
      wire rx_bad = rx_fp && !((rx_cn == 8'h00) && (rx_fn == 5'h00));
      wire [7:0] rx_b = rx_fp ? 8'h00 : rx_cn;
      assign rx_stat[g] = rx_st_r;

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rx_cnt_r <= `PLF_FRM_LAST;
          rx_frm_r <= 5'h00;
          rx_nb_r  <= 3'h0;
          rx_sh_r  <= 8'h00;
          rx_st_r  <= 1'b0;
          rx_payload[8*g+7:8*g] <= 8'h00;
          rx_payload_valid[g]   <= 1'b0;
        end else begin
          rx_payload_valid[g] <= 1'b0;
          if (rx_smp && rx_bad)
            rx_st_r <= 1'b1;
          else if (rx_clr[g])
            rx_st_r <= 1'b0;
          if (rx_smp) begin
            rx_cnt_r <= rx_b;
            rx_frm_r <= rx_fp ? 5'h00 : rx_fn;
            if (payload_bit(rx_b, mode, rate, spaced)) begin
              rx_sh_r <= {rx_sh_r[6:0], rxd_s[g]};
              rx_nb_r <= (rx_fp && rx_bad) ? 3'h1 : rx_nb_r + 3'h1;
              if (rx_nb_r == 3'h7 && !(rx_fp && rx_bad)) begin
                rx_payload[8*g+7:8*g] <= {rx_sh_r[6:0], rxd_s[g]};
                rx_payload_valid[g]   <= 1'b1;
              end
            end else if (rx_fp) begin
              rx_nb_r <= 3'h0;
            end
          end
        end
      end

      // Transmit clock selection: switch only while both sources are low, or at once on selector reset
      reg [3:0] cur_r;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cur_r             <= 4'h0;
          tx_pcm_clock_o[g] <= 1'b0;
          tx_pcm_clock_oe[g] <= 1'b0;
        end else begin
          tx_pcm_clock_oe[g] <= drive;
          if (sel_rst_r)
            cur_r <= want;
          else if (cur_r != want && !src_v[cur_r] && !src_v[want])
            cur_r <= want;
          tx_pcm_clock_o[g] <= src_v[cur_r];
        end
      end
      assign tx_lvl[g] = drive ? tx_pcm_clock_o[g] : tx_pcm_clock_s[g];

      // Transmit framing
      reg  [7:0] tx_cnt_r;
      reg  [4:0] tx_frm_r;
      reg  [2:0] tx_nb_r;
      reg  [7:0] tx_sh_r;
      reg        tx_st_r;
      wire tx_edge = cfg[`PLF_B_TXEDGE] ? (tx_lvl_p_r[g] && !tx_lvl[g])
                                        : (!tx_lvl_p_r[g] && tx_lvl[g]);
      wire tx_fp = !drive && (txfp_s[g] ^ cfg[`PLF_B_TXPOL]);
      wire [7:0] tx_cn = bit_step(tx_cnt_r, last);
      wire [4:0] tx_fn = frm_step(tx_frm_r, tx_cnt_r, last, flast);
      wire tx_bad = tx_fp && !((tx_cn == 8'h00) && (tx_fn == 5'h00));
      wire [7:0] tx_b = tx_fp ? 8'h00 : tx_cn;
      wire [2:0] tx_nbu = (tx_fp && tx_bad) ? 3'h0 : tx_nb_r;
      assign tx_stat[g] = tx_st_r;

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tx_cnt_r <= `PLF_FRM_LAST;
          tx_frm_r <= 5'h00;
          tx_nb_r  <= 3'h0;
          tx_sh_r  <= 8'h00;
          tx_st_r  <= 1'b0;
          tx_frame_pulse_o[g]  <= 1'b0;
          tx_frame_pulse_oe[g] <= 1'b0;
          tx_serial_data_o[g]  <= 1'b0;
          tx_serial_data_oe[g] <= 1'b0;
          tx_payload_take[g]   <= 1'b0;
        end else begin
          tx_payload_take[g]   <= 1'b0;
          tx_frame_pulse_oe[g] <= drive;
          if (tx_edge && tx_bad)
            tx_st_r <= 1'b1;
          else if (tx_clr[g])
            tx_st_r <= 1'b0;
          if (tx_edge) begin
            tx_cnt_r <= tx_b;
            tx_frm_r <= tx_fp ? 5'h00 : tx_fn;
            // Pulse spans exactly the first bit of each frame
            tx_frame_pulse_o[g] <= (tx_b == 8'h00) ^ cfg[`PLF_B_TXPOL];
            if (payload_bit(tx_b, mode, rate, spaced)) begin
              tx_serial_data_oe[g] <= 1'b1;
              tx_nb_r <= tx_nbu + 3'h1;
              if (tx_nbu == 3'h0) begin
                tx_serial_data_o[g] <= tx_payload[8*g+7];
                tx_sh_r             <= {tx_payload[8*g+6:8*g], 1'b0};
                tx_payload_take[g]  <= 1'b1;
              end else begin
                tx_serial_data_o[g] <= tx_sh_r[7];
                tx_sh_r             <= {tx_sh_r[6:0], 1'b0};
              end
            end else begin
              tx_serial_data_oe[g] <= 1'b0;
              tx_serial_data_o[g]  <= 1'b0;
              if (tx_fp)
                tx_nb_r <= 3'h0;
            end
          end
        end
      end
    end
  endgenerate

endmodule // plf_pcm_link

// [plf_link_checker_assertions.sv]
// Port-level assertions for the PCM link block, bound to its top module.
// Assumes APB writes land on the pready edge; watches link 0 and the rx clock picked as primary reference.
`include "plf_defines.vh"
module plf_link_checker #(
  parameter LINKS = 8
) (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  input wire [7:0]  rx_pcm_clock,
  input wire [7:0]  tx_pcm_clock_o,
  input wire [7:0]  tx_pcm_clock_oe,
  input wire [7:0]  tx_frame_pulse_o,
  input wire [7:0]  tx_frame_pulse_oe,
  input wire [7:0]  tx_serial_data_oe,
  input wire        pll_primary_ref_out,
  input wire [7:0]  rx_payload_valid,
  input wire [7:0]  tx_payload_take
);
  // ----------------------------------------------------------------
  // Shadow registers
  // ----------------------------------------------------------------
  logic [15:0] cfg0_r;
  logic [2:0]  pri_r;
  logic [4:0]  quiet_r;
  logic [3:0]  wide_r;
  wire         wr = psel && penable && pready && pwrite;
  // Settling gap after any write, so switch-over transients are not judged
  wire         quiet = quiet_r == 5'h1f;
  wire [3:0]   md = cfg0_r[3:0];
  wire         out_mode = md == 4'h1 || md == 4'h3 || md == 4'h6 || md == 4'h8;
  wire         act = (tx_frame_pulse_o[0] ^ cfg0_r[`PLF_B_TXPOL]) && tx_frame_pulse_oe[0];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg0_r <= `PLF_CFG_RST;
      pri_r <= 3'h0;
      quiet_r <= 5'h00;
      wide_r <= 4'h0;
    end else begin
      if (wr && paddr == `PLF_LINK_CFG) cfg0_r <= pwdata[15:0];
      if (wr && paddr == `PLF_PLL_REF_CTRL) pri_r <= pwdata[2:0];
      quiet_r <= wr ? 5'h00 : (quiet ? quiet_r : quiet_r + 5'h01);
      wide_r <= (act && quiet) ? ((wide_r == 4'hf) ? wide_r : wide_r + 4'h1) : 4'h0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_src_rise;
    quiet && out_mode && cfg0_r[15:12] == 4'h0 ##0 $rose(rx_pcm_clock[0]);
  endsequence
  sequence s_ref_rise;
    quiet ##0 $rose(rx_pcm_clock[pri_r]);
  endsequence
  a_clk_dir_mode: assert property (quiet |-> tx_pcm_clock_oe[0] == out_mode)
    else $error("tx clock direction does not follow mode");
  a_pulse_dir_mode: assert property (quiet |-> tx_frame_pulse_oe[0] == out_mode)
    else $error("tx pulse direction does not follow mode");
  a_pulse_one_bit: assert property (wide_r <= 4'hc)
    else $error("tx frame pulse longer than one bit");
  a_take_drives_data: assert property (tx_payload_take[0] |-> ##[0:16] tx_serial_data_oe[0])
    else $error("payload byte taken but data line not driven");
  a_valid_byte_gap: assert property (rx_payload_valid[0] |=> !rx_payload_valid[0] [*8])
    else $error("rx bytes completed too close together");
  a_tx_line_clock_follows_src: assert property (s_src_rise |-> ##[1:6] tx_pcm_clock_o[0])
    else $error("tx clock does not follow its source");
  a_pll_ref_follows: assert property (s_ref_rise |-> ##[1:6] pll_primary_ref_out)
    else $error("primary reference does not follow selected clock");
  a_apb_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  a_unmapped_error: assert property (pready && paddr > `PLF_CLK_ACT |-> pslverr)
    else $error("unmapped access without slave error");
endmodule // plf_link_checker

bind plf_pcm_link plf_link_checker #(.LINKS(LINKS)) i_plf_link_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .rx_pcm_clock(rx_pcm_clock), .tx_pcm_clock_o(tx_pcm_clock_o),
  .tx_pcm_clock_oe(tx_pcm_clock_oe), .tx_frame_pulse_o(tx_frame_pulse_o),
  .tx_frame_pulse_oe(tx_frame_pulse_oe), .tx_serial_data_oe(tx_serial_data_oe),
  .pll_primary_ref_out(pll_primary_ref_out), .rx_payload_valid(rx_payload_valid),
  .tx_payload_take(tx_payload_take));

// [plf_framer_model.sv]
// Behavioural E1 framer feeding all eight receive links alike.
// Assumes the device samples on the rising clock edge, pulse active high.
module plf_framer_model (
  // Receive pins toward the device
  output logic [7:0] rx_pcm_clock,
  output logic [7:0] rx_frame_pulse,
  output logic [7:0] rx_serial_data,
  // Moves the pulse off frame start while high
  input wire         misplace
);
  timeunit 1ns;
  timeprecision 100ps;
  int         b;
  logic [7:0] ch;
  // Channel n carries the value n, so the mapping shows in the bytes
  initial begin
    rx_pcm_clock = 8'h00;
    rx_frame_pulse = 8'h00;
    rx_serial_data = 8'h00;
    forever begin
      for (b = 0; b < 256; b++) begin
        ch = 8'(b >> 3);
        rx_pcm_clock = 8'h00;
        rx_frame_pulse = {8{b == (misplace ? 100 : 0)}};
        rx_serial_data = {8{ch[7 - (b & 7)]}};
        #100;
        rx_pcm_clock = 8'hff;
        #100;
      end
    end
  end
endmodule // plf_framer_model

// [tb.sv]
// Self-checking bench for the PCM link block over APB and link 0 pins.
// Assumes the framer model drives the receive pins of every link.
`include "plf_defines.vh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  refclk = 4'h0;
  logic        misplace = 1'b0;
  wire [31:0]  prdata;
  wire         pready, pslverr, pll_pri, pll_sec;
  wire [7:0]   rxc, rxp, rxd, txc, txc_oe, txp, txp_oe, txd, txd_oe, rxv, take;
  wire [63:0]  rx_payload;
  int          mismatches = 0;
  int          checks = 0;
  int          cycles = 0;
  int          take_cnt = 0;
  always #12.5 pclk = ~pclk;
  plf_framer_model i_plf_framer_model (.rx_pcm_clock(rxc), .rx_frame_pulse(rxp),
    .rx_serial_data(rxd), .misplace(misplace));
  plf_pcm_link i_plf_pcm_link (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_pcm_clock(rxc), .rx_frame_pulse(rxp),
    .rx_serial_data(rxd), .reference_clock_input(refclk), .tx_pcm_clock_i(8'h00),
    .tx_pcm_clock_o(txc), .tx_pcm_clock_oe(txc_oe), .tx_frame_pulse_i(8'h00),
    .tx_frame_pulse_o(txp), .tx_frame_pulse_oe(txp_oe), .tx_serial_data_o(txd),
    .tx_serial_data_oe(txd_oe), .pll_primary_ref_out(pll_pri),
    .pll_secondary_ref_out(pll_sec), .rx_payload(rx_payload), .rx_payload_valid(rxv),
    .tx_payload(64'ha5a5a5a5a5a5a5a5), .tx_payload_take(take));
  // ----------------------------------------------------------------
  // Timeout, reference clock at 200 ns, take counter
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles % 4 == 3) refclk[0] <= ~refclk[0];
    if (take[0] === 1'b1) take_cnt <= take_cnt + 1;
    if (cycles == 95000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(a, 1'b1, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(a, 1'b0, 32'h0, q, e);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] q;
    logic        e;
    rd(`PLF_LINK_CFG, q);
    chk("link cfg reset", {16'h0, `PLF_CFG_RST}, q);
    wr(`PLF_PLL_REF_CTRL, 32'h88);
    rd(`PLF_PLL_REF_CTRL, q);
    chk("selector reset clears", {26'h0, `PLF_PLLREF_RST}, q);
    apb(8'h40, 1'b0, 32'h0, q, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
  endtask
  task automatic t_dir();
    int   m;
    logic o;
    for (m = 1; m <= 8; m++) begin
      wr(`PLF_LINK_CFG, 32'(m));
      idle(4);
      o = (m == 1 || m == 3 || m == 6 || m == 8);
      chk("tx clock oe", {31'h0, o}, {31'h0, txc_oe[0]});
      chk("tx pulse oe", {31'h0, o}, {31'h0, txp_oe[0]});
    end
    wr(`PLF_LINK_CFG, 32'h3);
  endtask
  task automatic t_act();
    logic [4:0]  ids [4] = '{5'h00, 5'h08, 5'h10, 5'h13};
    logic [31:0] q;
    int          k;
    for (k = 0; k < 4; k++) begin
      wr(`PLF_CLK_ACT, {27'h0, ids[k]});
      idle(48);
      rd(`PLF_CLK_ACT, q);
      chk("clock activity", {31'h0, k != 3}, {31'h0, q[`PLF_B_ACTIVE]});
    end
  endtask
  task automatic t_rx();
    logic [7:0] prev;
    logic [7:0] nxt;
    int         k;
    int         n;
    k = 0;
    n = 0;
    prev = 8'h00;
    idle(2400);
    while (k < 64 && n < 8000) begin
      @(posedge pclk);
      n++;
      if (rxv[0] === 1'b1) begin
        nxt = (prev == 8'h0f) ? 8'h11 : ((prev == 8'h1f) ? 8'h01 : prev + 8'h01);
        if (k > 0) chk("rx channel order", {24'h0, nxt}, {24'h0, rx_payload[7:0]});
        prev = rx_payload[7:0];
        k++;
      end
    end
    chk("rx bytes seen", 32'd64, 32'(k));
  endtask
  task automatic t_sync();
    logic [31:0] q;
    wr(`PLF_RX_SYNC_STAT, 32'hff);
    idle(2200);
    rd(`PLF_RX_SYNC_STAT, q);
    chk("rx sync clean", 32'h0, {31'h0, q[0]});
    misplace <= 1'b1;
    idle(2200);
    rd(`PLF_RX_SYNC_STAT, q);
    chk("rx sync flag", 32'h1, {31'h0, q[0]});
    misplace <= 1'b0;
  endtask
  task automatic rise(input logic pol);
    logic p;
    int   n;
    p = 1'b1;
    n = 0;
    while (n < 5000) begin
      @(posedge pclk);
      n++;
      if (p === 1'b0 && (txp[0] ^ pol) === 1'b1) break;
      p = txp[0] ^ pol;
    end
  endtask
  task automatic t_frame(input logic [15:0] cfg, input int bits, input int takes);
    int   n;
    int   s;
    int   w;
    logic a;
    logic p;
    wr(`PLF_LINK_CFG, {16'h0, cfg});
    rise(cfg[`PLF_B_TXPOL]);
    rise(cfg[`PLF_B_TXPOL]);
    s = take_cnt;
    n = 0;
    w = 0;
    a = 1'b1;
    p = 1'b1;
    while (!(a === 1'b1 && p === 1'b0) && n < 5000) begin
      p = a;
      w += (a === 1'b1);
      n++;
      @(posedge pclk);
      a = txp[0] ^ cfg[`PLF_B_TXPOL];
    end
    chk("tx data oe bit 0", {31'h0, cfg == 16'h0011}, {31'h0, txd_oe[0]});
    chk("frame cycles", 32'h1, {31'h0, n >= bits * 8 - 4 && n <= bits * 8 + 4});
    chk("takes per frame", 32'(takes), 32'(take_cnt - s));
    chk("pulse width", 32'h1, {31'h0, w >= 6 && w <= 10});
  endtask
  task automatic t_pll();
    int   n;
    int   m;
    logic p;
    logic s;
    wr(`PLF_PLL_REF_CTRL, 32'h2a);
    idle(40);
    n = 0;
    m = 0;
    p = pll_pri;
    s = pll_sec;
    repeat (64) begin
      @(posedge pclk);
      n += (pll_pri !== p);
      m += (pll_sec !== s);
      p = pll_pri;
      s = pll_sec;
    end
    chk("primary ref toggles", 32'h1, {31'h0, n >= 12});
    chk("secondary ref toggles", 32'h1, {31'h0, m >= 12});
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_dir();
    t_act();
    t_rx();
    t_sync();
    t_frame(16'h0003, 256, 30);
    t_frame(16'h0103, 256, 30);
    t_frame(16'h8003, 256, 30);
    t_frame(16'h0001, 193, 24);
    t_frame(16'h0031, 256, 24);
    t_frame(16'h0011, 256, 24);
    t_pll();
    stop_test();
  end
endmodule // tb
